/* File: hw/rsfec_pkg.sv */
// Constants and types shared by the RS-FEC configuration and status logic
package rsfec_pkg;

   // Lane count and status field layout
   localparam int unsigned LANES          = 2;
   localparam int unsigned FILL_W         = 14;
   localparam int unsigned FILL_WHOLE_MSB = 13;
   localparam int unsigned FILL_WHOLE_LSB = 7;
   localparam int unsigned FILL_FRAC_MSB  = 6;
   localparam int unsigned FILL_FRAC_LSB  = 0;
   localparam int unsigned FRAC_W         = 7;
   localparam logic [6:0]  FRAC_LIMIT     = 7'h42;
   localparam logic [6:0]  FRAC_MAX       = 7'h41;
   localparam int unsigned SYM_INC_W      = 3;
   localparam int unsigned MAP_W          = 2;

   // Error-rate window
   localparam int unsigned CW_CNT_W       = 13;
   localparam logic [12:0] SER_WINDOW_LAST = 13'h1fff;
   localparam int unsigned SER_SUM_W      = 16;
   localparam logic [15:0] SER_THRESHOLD  = 16'h01a1;
   localparam logic [15:0] SER_SUM_MAX    = 16'hffff;

   // Values after reset
   localparam logic [13:0] FILL_RST       = 14'h0000;
   localparam logic [2:0]  SYM_RST        = 3'h0;
   localparam logic [1:0]  MAP_RST        = 2'h0;
   localparam logic [12:0] CW_CNT_RST     = 13'h0000;
   localparam logic [15:0] SER_SUM_RST    = 16'h0000;

   // Configuration capture state
   typedef enum logic [2:0] {
      ST_SAMPLE  = 3'b001,
      ST_FEC_ON  = 3'b010,
      ST_BYPASS  = 3'b100
   } cfg_state_t;

endpackage

/* File: hw/rsfec_lane_if.sv */
// Per-lane status carrier between the top and the lane status module
interface rsfec_lane_if;
   import rsfec_pkg::*;
   logic                 enable;
   logic                 lock_raw;
   logic [FILL_W-1:0]    fill_raw;
   logic [SYM_INC_W-1:0] sym_raw;
   logic                 lock_q;
   logic [FILL_W-1:0]    fill_q;
   logic [SYM_INC_W-1:0] sym_q;

   modport lane (
      input  enable,
      input  lock_raw,
      input  fill_raw,
      input  sym_raw,
      output lock_q,
      output fill_q,
      output sym_q
   );

   modport top (
      output enable,
      output lock_raw,
      output fill_raw,
      output sym_raw,
      input  lock_q,
      input  fill_q,
      input  sym_q
   );
endinterface

/* File: hw/rsfec_lane_stat.sv */
// Registered status of one receive lane: marker lock, deskew fill, errors
module rsfec_lane_stat
   import rsfec_pkg::*;
(
   // Clock and reset
   input  wire logic  clk_sys,
   input  wire logic  reset_n,
   // Lane carrier
   rsfec_lane_if.lane l
);

   logic [FRAC_W-1:0] frac_in;

   assign frac_in = l.fill_raw[FILL_FRAC_MSB:FILL_FRAC_LSB];

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         l.lock_q <= 1'b0;
      end else begin
         l.lock_q <= l.enable & l.lock_raw; // [RQ8]
      end
   end

   // Fraction is in 1/66 cycle, so a raw value past 65 is clamped
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         l.fill_q <= FILL_RST;
      end else if (!l.enable) begin
         l.fill_q <= FILL_RST;
      end else if (frac_in >= FRAC_LIMIT) begin
         l.fill_q <= {l.fill_raw[FILL_WHOLE_MSB:FILL_WHOLE_LSB],
                      FRAC_MAX}; // [RQ9]
      end else begin
         l.fill_q <= l.fill_raw; // [RQ9]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         l.sym_q <= SYM_RST;
      end else begin
         l.sym_q <= l.enable ? l.sym_raw : SYM_RST; // [RQ14]
      end
   end

endmodule // rsfec_lane_stat

/* File: hw/rsfec_config_status_ports.sv */
// RS-FEC configuration capture and status reporting, one clock domain
//
// Notes on behaviour
// [RQ1] FEC enable 1 runs RS-FEC, 0 bypasses it; changes act only after reset.
// [RQ2] Every configuration input is sampled once, first cycle after reset.
// [RQ3] Correction enable 0 means detect only; 1 also corrects errors.
// [RQ4] Indication enable 1 flags detected errors to PCS; 0 bypasses flagging.
// [RQ5] Conformance 0 with correction and indication off bypasses the decoder.
// [RQ6] TX block lock output is 1 when locked, 0 when unlocked.
// [RQ7] TX alignment output is 1 when transmit lanes are aligned.
// [RQ8] Per-lane marker lock outputs plus one overall RX alignment output.
// [RQ9] Per-lane 14-bit deskew delay: bits 13..7 cycles, 6..0 in 1/66 cycle.
// [RQ10] Two-bit lane map: bit n is FEC lane index on PMA lane n.
// [RQ11] High SER only in bypass-indication mode: over 417 errors per 8192.
// [RQ12] One pulse per codeword the decoder corrected.
// [RQ13] One pulse per codeword the decoder could not correct.
// [RQ14] Per-lane 3-bit symbol error increment for the current cycle.
// [RQ15] Errors are counted over consecutive non-overlapping codeword blocks.
// [RQ16] Config and RX status on the receive clock, TX status on transmit; here all run on clk_sys.
module rsfec_config_status_ports
   import rsfec_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 reset_n,
   // Configuration, sampled after reset
   input  wire logic                 fec_enable,
   input  wire logic                 correction_enable,
   input  wire logic                 indication_enable,
   input  wire logic                 ieee_conform_mode,
   // Transmit status from the encoder side
   input  wire logic                 tx_block_lock_in,
   input  wire logic                 tx_lanes_aligned_in,
   // Receive lane status from the decoder side
   input  wire logic                 rx_marker_lock_lane0_in,
   input  wire logic                 rx_marker_lock_lane1_in,
   input  wire logic                 rx_lanes_aligned_in,
   input  wire logic [FILL_W-1:0]    rx_fill_lane0_in,
   input  wire logic [FILL_W-1:0]    rx_fill_lane1_in,
   input  wire logic [MAP_W-1:0]     rx_lane_map_in,
   // Decoder codeword results
   input  wire logic                 cw_done_in,
   input  wire logic                 cw_errored_in,
   input  wire logic                 cw_correctable_in,
   input  wire logic [SYM_INC_W-1:0] sym_err_lane0_in,
   input  wire logic [SYM_INC_W-1:0] sym_err_lane1_in,
   // Mode controls toward the datapath
   output logic                      fec_active,
   output logic                      decoder_bypass,
   output logic                      apply_correction,
   output logic                      mark_errors_to_pcs,
   output logic                      pcs_error_mark_pulse,
   // Transmit status
   output logic                      tx_pcs_block_locked,
   output logic                      tx_lanes_aligned,
   // Receive status
   output logic                      rx_marker_locked_lane0,
   output logic                      rx_marker_locked_lane1,
   output logic                      rx_lanes_aligned,
   output logic [FILL_W-1:0]         rx_fill_lane0,
   output logic [FILL_W-1:0]         rx_fill_lane1,
   output logic [MAP_W-1:0]          rx_lane_map,
   output logic                      high_symbol_error_rate,
   // Statistics increments
   output logic                      fixed_codeword_pulse,
   output logic                      unfixable_codeword_pulse,
   output logic [SYM_INC_W-1:0]      sym_err_inc_lane0,
   output logic [SYM_INC_W-1:0]      sym_err_inc_lane1
);

   cfg_state_t             state_q;
   logic                   correct_q;
   logic                   indicate_q;
   logic                   ieee_q;
   logic                   fec_on;
   logic                   bypass_dec;
   logic                   decoding;
   logic                   bypass_ind;
   logic                   cw_fixed;
   logic                   cw_unfixed;
   logic [CW_CNT_W-1:0]    cw_cnt_q;
   logic [SER_SUM_W-1:0]   ser_sum_q;
   logic [SER_SUM_W:0]     ser_add;
   logic [SER_SUM_W-1:0]   ser_now;
   logic                   window_end;

   // Configuration is latched once; later input changes wait for reset
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_q <= ST_SAMPLE;
      end else begin
         case (state_q)
            ST_SAMPLE: begin
               state_q <= fec_enable ? ST_FEC_ON : ST_BYPASS; // [RQ1] [RQ2]
            end
            ST_FEC_ON: begin
               state_q <= ST_FEC_ON;
            end
            ST_BYPASS: begin
               state_q <= ST_BYPASS;
            end
            default: begin
               state_q <= ST_SAMPLE;
            end
         endcase
      end
   end

   // Each bit is captured in the same cycle as the state decision
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         correct_q <= 1'b0;
      end else if (state_q == ST_SAMPLE) begin
         correct_q <= correction_enable; // [RQ2] [RQ3]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         indicate_q <= 1'b0;
      end else if (state_q == ST_SAMPLE) begin
         indicate_q <= indication_enable; // [RQ2] [RQ4]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ieee_q <= 1'b0;
      end else if (state_q == ST_SAMPLE) begin
         ieee_q <= ieee_conform_mode; // [RQ2] [RQ5]
      end
   end

   assign fec_on     = (state_q == ST_FEC_ON); // [RQ1]
   assign bypass_dec = fec_on & ~ieee_q & ~correct_q & ~indicate_q; // [RQ5]
   assign decoding   = fec_on & ~bypass_dec;
   assign bypass_ind = decoding & ~indicate_q; // [RQ11]

   // Detect-only mode reports correctable codewords as uncorrected
   assign cw_fixed   = decoding & cw_done_in & cw_errored_in &
                       cw_correctable_in & correct_q; // [RQ3]
   assign cw_unfixed = decoding & cw_done_in & cw_errored_in &
                       (~cw_correctable_in | ~correct_q); // [RQ3]

   // Mode levels lag the capture by one edge, so the sample cycle shows 0
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         fec_active <= 1'b0;
      end else begin
         fec_active <= fec_on; // [RQ1]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         decoder_bypass <= 1'b0;
      end else begin
         decoder_bypass <= bypass_dec; // [RQ5]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         apply_correction <= 1'b0;
      end else begin
         apply_correction <= decoding & correct_q; // [RQ3]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         mark_errors_to_pcs <= 1'b0;
      end else begin
         mark_errors_to_pcs <= decoding & indicate_q; // [RQ4]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pcs_error_mark_pulse <= 1'b0;
      end else begin
         pcs_error_mark_pulse <= cw_unfixed & indicate_q; // [RQ4]
      end
   end

   // Transmit status; single clock here, so no crossing is needed
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tx_pcs_block_locked <= 1'b0;
      end else begin
         tx_pcs_block_locked <= fec_on & tx_block_lock_in; // [RQ6] [RQ16]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tx_lanes_aligned <= 1'b0;
      end else begin
         tx_lanes_aligned <= fec_on & tx_lanes_aligned_in; // [RQ7] [RQ16]
      end
   end

   // Receive status reads 0 in bypass, so stale lock never leaks out
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rx_lanes_aligned <= 1'b0;
      end else begin
         rx_lanes_aligned <= fec_on & rx_lanes_aligned_in; // [RQ8]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rx_lane_map <= MAP_RST;
      end else begin
         rx_lane_map <= fec_on ? rx_lane_map_in : MAP_RST; // [RQ10]
      end
   end

   // Per-lane registers
   rsfec_lane_if lane0_if ();
   rsfec_lane_if lane1_if ();

   assign lane0_if.enable   = fec_on;
   assign lane0_if.lock_raw = rx_marker_lock_lane0_in;
   assign lane0_if.fill_raw = rx_fill_lane0_in;
   assign lane0_if.sym_raw  = decoding ? sym_err_lane0_in : SYM_RST;
   assign lane1_if.enable   = fec_on;
   assign lane1_if.lock_raw = rx_marker_lock_lane1_in;
   assign lane1_if.fill_raw = rx_fill_lane1_in;
   assign lane1_if.sym_raw  = decoding ? sym_err_lane1_in : SYM_RST;

   rsfec_lane_stat u_lane0 (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .l       (lane0_if.lane)
   );

   rsfec_lane_stat u_lane1 (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .l       (lane1_if.lane)
   );

   assign rx_marker_locked_lane0 = lane0_if.lock_q;
   assign rx_marker_locked_lane1 = lane1_if.lock_q;
   assign rx_fill_lane0          = lane0_if.fill_q;
   assign rx_fill_lane1          = lane1_if.fill_q;
   assign sym_err_inc_lane0      = lane0_if.sym_q;
   assign sym_err_inc_lane1      = lane1_if.sym_q;

   // One pulse per codeword; back-to-back codewords give back-to-back pulses
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         fixed_codeword_pulse <= 1'b0;
      end else begin
         fixed_codeword_pulse <= cw_fixed; // [RQ12]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         unfixable_codeword_pulse <= 1'b0;
      end else begin
         unfixable_codeword_pulse <= cw_unfixed; // [RQ13]
      end
   end

   // Error-rate window; sum saturates so a noisy block cannot wrap low
   assign ser_add    = {1'b0, ser_sum_q} +
                       {{(SER_SUM_W-SYM_INC_W+1){1'b0}}, lane0_if.sym_raw} +
                       {{(SER_SUM_W-SYM_INC_W+1){1'b0}}, lane1_if.sym_raw};
   assign ser_now    = ser_add[SER_SUM_W] ? SER_SUM_MAX
                                          : ser_add[SER_SUM_W-1:0];
   assign window_end = cw_done_in & (cw_cnt_q == SER_WINDOW_LAST);

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cw_cnt_q <= CW_CNT_RST;
      end else if (!bypass_ind) begin
         cw_cnt_q <= CW_CNT_RST;
      end else if (cw_done_in) begin
         cw_cnt_q <= cw_cnt_q + 13'h0001; // [RQ15]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ser_sum_q <= SER_SUM_RST;
      end else if (!bypass_ind || window_end) begin
         ser_sum_q <= SER_SUM_RST; // [RQ15]
      end else begin
         ser_sum_q <= ser_now; // [RQ15]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         high_symbol_error_rate <= 1'b0;
      end else if (!bypass_ind) begin
         high_symbol_error_rate <= 1'b0; // [RQ11]
      end else if (window_end) begin
         high_symbol_error_rate <= (ser_now > SER_THRESHOLD); // [RQ11]
      end
   end

endmodule // rsfec_config_status_ports

/* File: tb/rsfec_cfg_checker.sv */
// Assertions on the RS-FEC configuration and status ports
module rsfec_cfg_checker
   import rsfec_pkg::*;
(
   // Clock and reset
   input wire logic                 clk_sys,
   input wire logic                 reset_n,
   // Watched inputs
   input wire logic                 cw_done_in,
   input wire logic                 cw_errored_in,
   input wire logic                 cw_correctable_in,
   input wire logic                 tx_block_lock_in,
   input wire logic [FILL_W-1:0]    rx_fill_lane0_in,
   input wire logic [SYM_INC_W-1:0] sym_err_lane0_in,
   // Watched outputs
   input wire logic                 fec_active,
   input wire logic                 decoder_bypass,
   input wire logic                 apply_correction,
   input wire logic                 mark_errors_to_pcs,
   input wire logic                 pcs_error_mark_pulse,
   input wire logic                 tx_pcs_block_locked,
   input wire logic                 rx_lanes_aligned,
   input wire logic [FILL_W-1:0]    rx_fill_lane0,
   input wire logic [MAP_W-1:0]     rx_lane_map,
   input wire logic                 high_symbol_error_rate,
   input wire logic                 fixed_codeword_pulse,
   input wire logic                 unfixable_codeword_pulse,
   input wire logic [SYM_INC_W-1:0] sym_err_inc_lane0
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // Latched mode outputs stand for the decoder state one edge earlier
   sequence s_cw_bad;
      cw_done_in && cw_errored_in && fec_active && !decoder_bypass;
   endsequence
   sequence s_cw_lost;
      s_cw_bad ##0 (!cw_correctable_in || !apply_correction);
   endsequence
   a_fixed_cw_pulse: assert property (s_cw_bad ##0
      (cw_correctable_in && apply_correction) |=> fixed_codeword_pulse)
      else $error("corrected codeword pulse missing");
   a_unfix_cw_pulse: assert property (s_cw_lost |=>
      unfixable_codeword_pulse && !fixed_codeword_pulse)
      else $error("uncorrected codeword pulse wrong");
   a_pcs_err_mark: assert property (s_cw_lost ##0 mark_errors_to_pcs
      |=> pcs_error_mark_pulse) else $error("error mark missing");
   a_tx_lock_follow: assert property (fec_active |=>
      tx_pcs_block_locked == $past(tx_block_lock_in))
      else $error("tx block lock not copied");
   a_bypass_quiet: assert property (!fec_active [*2] |->
      !rx_lanes_aligned && rx_lane_map == 2'h0 && rx_fill_lane0 == FILL_RST)
      else $error("status not quiet in bypass");
   a_fill_whole_copy: assert property (fec_active |=>
      rx_fill_lane0[FILL_WHOLE_MSB:FILL_WHOLE_LSB] ==
      $past(rx_fill_lane0_in[FILL_WHOLE_MSB:FILL_WHOLE_LSB]))
      else $error("deskew whole cycles wrong");
   a_sym_inc_copy: assert property (fec_active && !decoder_bypass |=>
      sym_err_inc_lane0 == $past(sym_err_lane0_in))
      else $error("symbol error increment wrong");
   a_cfg_held: assert property ($past(fec_active) |->
      $stable({fec_active, decoder_bypass, apply_correction,
      mark_errors_to_pcs}))
      else $error("latched mode changed");
   a_high_ser_mode: assert property (high_symbol_error_rate |->
      fec_active && !decoder_bypass && !mark_errors_to_pcs)
      else $error("high error rate outside bypass indication");
endmodule // rsfec_cfg_checker

bind rsfec_config_status_ports rsfec_cfg_checker chk_u (.*);

/* File: tb/stat_counters.sv */
// Statistics counters fed by the increment outputs
module stat_counters (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // Increments
   input  wire logic       fixed_pulse,
   input  wire logic       unfix_pulse,
   input  wire logic [2:0] inc0,
   input  wire logic [2:0] inc1,
   // Totals
   output logic [15:0]     fixed_cnt,
   output logic [15:0]     unfix_cnt,
   output logic [15:0]     sym_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pulses are counted per edge, so a held level would count repeatedly
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         fixed_cnt <= 16'h0000;
         unfix_cnt <= 16'h0000;
         sym_cnt   <= 16'h0000;
      end else begin
         fixed_cnt <= fixed_cnt + 16'(fixed_pulse);
         unfix_cnt <= unfix_cnt + 16'(unfix_pulse);
         sym_cnt   <= sym_cnt + 16'(inc0) + 16'(inc1);
      end
   end
endmodule // stat_counters

/* File: tb/testbench.sv */
// Self-checking bench for the RS-FEC configuration and status ports
`define CHK(nm, exp, got) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("Error %s expected %0h seen %0h", nm, exp, got); \
   end \
end
module testbench
   import rsfec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  cfg = 4'h0;
   logic [4:0]  st = 5'h1f;
   logic [13:0] fl0 = 14'h0000;
   logic [13:0] fl1 = 14'h0000;
   logic [1:0]  map = 2'h0;
   logic [2:0]  cw = 3'h0;
   logic [2:0]  sy0 = 3'h0;
   logic [2:0]  sy1 = 3'h0;
   logic [3:0]  md;
   logic [4:0]  so;
   logic [13:0] f0o;
   logic [13:0] f1o;
   logic [1:0]  mpo;
   logic        hs, fx, ux, pm;
   logic [2:0]  i0, i1;
   logic [15:0] nfx, nux, nsy;
   int          num_errors = 0;
   int          cmp_count = 0;

   always #10 clk_sys = ~clk_sys;

   rsfec_config_status_ports dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
      .fec_enable(cfg[3]), .correction_enable(cfg[2]),
      .indication_enable(cfg[1]), .ieee_conform_mode(cfg[0]),
      .tx_block_lock_in(st[4]), .tx_lanes_aligned_in(st[3]),
      .rx_marker_lock_lane0_in(st[2]), .rx_marker_lock_lane1_in(st[1]),
      .rx_lanes_aligned_in(st[0]), .rx_fill_lane0_in(fl0),
      .rx_fill_lane1_in(fl1), .rx_lane_map_in(map), .cw_done_in(cw[2]),
      .cw_errored_in(cw[1]), .cw_correctable_in(cw[0]),
      .sym_err_lane0_in(sy0), .sym_err_lane1_in(sy1),
      .fec_active(md[3]), .decoder_bypass(md[2]),
      .apply_correction(md[1]), .mark_errors_to_pcs(md[0]),
      .pcs_error_mark_pulse(pm), .tx_pcs_block_locked(so[4]),
      .tx_lanes_aligned(so[3]), .rx_marker_locked_lane0(so[2]),
      .rx_marker_locked_lane1(so[1]), .rx_lanes_aligned(so[0]),
      .rx_fill_lane0(f0o), .rx_fill_lane1(f1o), .rx_lane_map(mpo),
      .high_symbol_error_rate(hs), .fixed_codeword_pulse(fx),
      .unfixable_codeword_pulse(ux), .sym_err_inc_lane0(i0),
      .sym_err_inc_lane1(i1));

   stat_counters cnt_u (.clk_sys(clk_sys), .reset_n(reset_n),
      .fixed_pulse(fx), .unfix_pulse(ux), .inc0(i0), .inc1(i1),
      .fixed_cnt(nfx), .unfix_cnt(nux), .sym_cnt(nsy));

   task tally_and_finish;
      $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Reset, then flip the configuration once it has been sampled
   task reset_cfg(input logic [3:0] c);
      @(negedge clk_sys);
      reset_n = 1'b0;
      cfg = c;
      repeat (8) @(negedge clk_sys);
      reset_n = 1'b1;
      @(negedge clk_sys);
      cfg = ~c;
      @(negedge clk_sys);
   endtask

   task automatic t_modes;
      logic [3:0] tbl [6] = '{4'hf, 4'h8, 4'hc, 4'h7, 4'ha, 4'h9};
      logic       byp;
      logic [3:0] exp_md;
      foreach (tbl[k]) begin
         reset_cfg(tbl[k]);
         byp = tbl[k] == 4'h8;
         exp_md = {tbl[k][3], byp, tbl[k][3] & !byp & tbl[k][2],
                   tbl[k][3] & !byp & tbl[k][1]};
         `CHK("modes", exp_md, md)
         `CHK("status", {5{tbl[k][3]}}, so)
         repeat (3) @(negedge clk_sys);
         `CHK("held modes", exp_md, md)
      end
      $display("modes test done");
   endtask

   task t_status;
      reset_cfg(4'hf);
      st = 5'h0a;
      fl0 = 14'h3fc1;
      fl1 = 14'h017f;
      map = 2'h2;
      @(negedge clk_sys);
      `CHK("status", 5'h0a, so)
      `CHK("fill0", 14'h3fc1, f0o)
      `CHK("fill1", {7'h02, FRAC_MAX}, f1o)
      `CHK("map", 2'h2, mpo)
      st = 5'h15;
      map = 2'h1;
      @(negedge clk_sys);
      `CHK("status", 5'h15, so)
      `CHK("map", 2'h1, mpo)
      $display("status test done");
   endtask

   // Back-to-back codewords with full correction and detect-only
   task automatic t_cw;
      logic [2:0] tbl [4] = '{3'h7, 3'h6, 3'h4, 3'h3};
      logic       cor;
      logic       eux;
      for (int m = 0; m < 2; m++) begin
         cor = m == 0;
         reset_cfg({1'b1, cor, 2'h3});
         foreach (tbl[k]) begin
            cw = tbl[k];
            sy0 = 3'(k);
            sy1 = 3'(7 - k);
            @(negedge clk_sys);
            eux = tbl[k][2:1] == 2'h3 && !(cor && tbl[k][0]);
            `CHK("fixed", tbl[k] == 3'h7 && cor, fx)
            `CHK("unfixed", eux, ux)
            `CHK("mark", eux, pm)
            `CHK("inc", {3'(k), 3'(7 - k)}, {i0, i1})
         end
         cw = 3'h0;
         sy0 = 3'h0;
         sy1 = 3'h0;
         @(negedge clk_sys);
         `CHK("fixed total", 16'(cor), nfx)
         `CHK("unfixed total", 16'(2 - cor), nux)
         `CHK("symbol total", 16'h001c, nsy)
      end
      $display("codeword test done");
   endtask

   // One window of codewords carrying 417 symbol errors plus extra;
   // inputs stay driven so the next window starts with no gap
   task win(input int extra, input logic exp);
      for (int i = 0; i < 8192; i++) begin
         cw = 3'h4;
         sy0 = (i < 139) ? 3'h3 : 3'h0;
         sy1 = (i < extra) ? 3'h1 : 3'h0;
         @(negedge clk_sys);
      end
      `CHK("high ser", exp, hs)
   endtask

   task t_hiser;
      reset_cfg(4'hd);
      win(0, 1'b0);
      win(1, 1'b1);
      win(0, 1'b0);
      $display("error rate test done");
   endtask

   initial begin
      #1200000;
      num_errors++;
      tally_and_finish;
   end

   initial begin
      t_modes;
      t_status;
      t_cw;
      t_hiser;
      tally_and_finish;
   end
endmodule // testbench
